// ---- hdl/relay_pkg.sv ----
// Shared constants, types and state layout for the selector-unit channel decoder
package relay_pkg;
   localparam int SEL_W       = 4;
   localparam int GROUPS      = 4;
   localparam int GROUP_SIZE  = 8;
   localparam int CHANNELS    = GROUPS * GROUP_SIZE;
   localparam int RELAYS      = 10;
   localparam int SYNC_W      = SEL_W + GROUPS + 2;
   localparam int SYNC_STAGES = 2;

   // Bit positions inside the synchronised input word
   localparam int POS_SEL    = 0;
   localparam int POS_EN     = POS_SEL + SEL_W;
   localparam int POS_RAISE  = POS_EN + GROUPS;
   localparam int POS_LOWER  = POS_RAISE + 1;

   // Group enables idle high, commands idle low
   localparam logic [SYNC_W-1:0] SYNC_RESET = {2'b00, {GROUPS{1'b1}}, {SEL_W{1'b0}}};
   localparam logic [RELAYS-1:0] RELAY_RESET = '0;

   // Channel ranges of the unit variants
   typedef enum {UNIT_1_10, UNIT_11_20, UNIT_21_30} unit_range_t;
   localparam int UNIT_SPAN = 10;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [RELAYS-1:0] relayPull;
      logic [RELAYS-1:0] meterConnect;
      logic [RELAYS-1:0] raiseClose;
      logic [RELAYS-1:0] lowerClose;
      logic              raiseOn;
      logic              lowerOn;
   } state_t;
endpackage

// ---- hdl/group_dec_if.sv ----
// Carrier between the top module and one group decoder
`timescale 1ns/100ps
interface group_dec_if;
   logic [relay_pkg::SEL_W-1:0]      code;
   logic                             enable;
   logic [relay_pkg::GROUP_SIZE-1:0] hot;

   modport top (output code, output enable, input hot);
   modport dec (input code, input enable, output hot);
endinterface

// ---- hdl/group_decoder.sv ----
// One group decoder: within-group code to one-hot channel lines
`timescale 1ns/100ps
module group_decoder (
   group_dec_if.dec port
);
   always_comb begin
      for (int i = 0; i < relay_pkg::GROUP_SIZE; i++) begin
         // Codes of eight and above hit no line, so they release everything
         port.hot[i] = port.enable && (port.code == relay_pkg::SEL_W'(i));
      end
   end
endmodule

// ---- hdl/channel_relay_decoder.sv ----
// Selector-unit channel decoder with relay, metering and raise/lower drive
`timescale 1ns/100ps
module channel_relay_decoder #(
   parameter relay_pkg::unit_range_t UNIT = relay_pkg::UNIT_1_10
) (
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic [relay_pkg::SEL_W-1:0]  chanSel,
   input  wire logic                         group_en_first_n,
   input  wire logic                         group_en_second_n,
   input  wire logic                         group_en_third_n,
   input  wire logic                         group_en_fourth_n,
   input  wire logic                         raise_cmd,
   input  wire logic                         lower_cmd,
   output logic      [relay_pkg::RELAYS-1:0] relayPullOe,
   output logic      [relay_pkg::RELAYS-1:0] meterConnect,
   output logic      [relay_pkg::RELAYS-1:0] raiseClose,
   output logic      [relay_pkg::RELAYS-1:0] lowerClose,
   output logic                              raiseRelayOn,
   output logic                              lowerRelayOn
);
   // First channel of this unit, counted from channel 0 of the first group
   localparam int BASE = relay_pkg::UNIT_SPAN * int'(UNIT) + 1;

   relay_pkg::state_t                  state_r;
   relay_pkg::state_t                  state_nxt;
   logic [relay_pkg::SYNC_W-1:0]       pinWord;
   logic [relay_pkg::SEL_W-1:0]        selCode;
   logic [relay_pkg::GROUPS-1:0]       enN;
   logic                               enLegal;
   logic [relay_pkg::CHANNELS-1:0]     chanHot;
   logic [relay_pkg::RELAYS-1:0]       relayHot;
   logic                               raiseDrive;
   logic                               lowerDrive;

   assign pinWord = {lower_cmd, raise_cmd, group_en_fourth_n, group_en_third_n,
                     group_en_second_n, group_en_first_n, chanSel};

   assign selCode = state_r.sync2[relay_pkg::POS_SEL +: relay_pkg::SEL_W];
   assign enN     = state_r.sync2[relay_pkg::POS_EN +: relay_pkg::GROUPS];

   // Two enables low at once would close two relays, so such a word releases all
   assign enLegal = ($countones(~enN) == 1);

   group_dec_if decIf [relay_pkg::GROUPS] ();

   genvar g;
   generate
      for (g = 0; g < relay_pkg::GROUPS; g++) begin : gDec
         assign decIf[g].code   = selCode;
         // Enable order fixes groups 0-7, 8-15, 16-23, 24-31
         assign decIf[g].enable = enLegal && !enN[g];
         assign chanHot[g*relay_pkg::GROUP_SIZE +: relay_pkg::GROUP_SIZE] = decIf[g].hot;
         group_decoder uDec (
            .port (decIf[g])
         );
      end
   endgenerate

   // Only the unit's own ten channels reach its relays; the rest belong to other units on the bus, except channels 0 and 31, which no unit uses
   assign relayHot = chanHot[BASE +: relay_pkg::RELAYS];

   // Lower relay's back contacts break the raise path
   assign raiseDrive = state_r.sync2[relay_pkg::POS_RAISE] && !state_r.sync2[relay_pkg::POS_LOWER];
   assign lowerDrive = state_r.sync2[relay_pkg::POS_LOWER];

   always_comb begin
      state_nxt       = state_r;
      state_nxt.sync1 = pinWord;
      state_nxt.sync2 = state_r.sync1;
      state_nxt.relayPull    = relayHot;
      state_nxt.meterConnect = relayHot;
      state_nxt.raiseOn      = raiseDrive;
      state_nxt.lowerOn      = lowerDrive;
      state_nxt.raiseClose   = relayHot & {relay_pkg::RELAYS{raiseDrive}};
      state_nxt.lowerClose   = relayHot & {relay_pkg::RELAYS{lowerDrive}};
      if (!resetn) begin
         state_nxt.sync1        = relay_pkg::SYNC_RESET;
         state_nxt.sync2        = relay_pkg::SYNC_RESET;
         state_nxt.relayPull    = relay_pkg::RELAY_RESET;
         state_nxt.meterConnect = relay_pkg::RELAY_RESET;
         state_nxt.raiseClose   = relay_pkg::RELAY_RESET;
         state_nxt.lowerClose   = relay_pkg::RELAY_RESET;
         state_nxt.raiseOn      = 1'b0;
         state_nxt.lowerOn      = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      state_r <= state_nxt;
   end

   assign relayPullOe  = state_r.relayPull;
   assign meterConnect = state_r.meterConnect;
   assign raiseClose   = state_r.raiseClose;
   assign lowerClose   = state_r.lowerClose;
   assign raiseRelayOn = state_r.raiseOn;
   assign lowerRelayOn = state_r.lowerOn;
endmodule

// ---- bench/relay_decoder_asserts.sv ----
// Port checks for the channel relay decoder
`timescale 1ns/100ps
module relay_decoder_asserts (
   input wire logic       clk, resetn, raise_cmd, lower_cmd, raiseRelayOn, lowerRelayOn,
   input wire logic       group_en_first_n, group_en_second_n, group_en_third_n, group_en_fourth_n,
   input wire logic [3:0] chanSel,
   input wire logic [9:0] relayPullOe, meterConnect, raiseClose, lowerClose
);
   logic [1:0] up;
   wire        idle = &{group_en_first_n, group_en_second_n, group_en_third_n, group_en_fourth_n};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Outputs lag three edges, so checks against the inputs wait until the pipe is full after reset
   always_ff @(posedge clk) up <= resetn ? up + (up != 2'h3) : 2'h0;
   meter_follow_a: assert property (meterConnect == relayPullOe) else $error("meter");
   one_relay_a: assert property ($onehot0(relayPullOe)) else $error("two relays");
   raise_contact_a: assert property (raiseClose == (raiseRelayOn ? relayPullOe : '0)) else $error("raise");
   lower_contact_a: assert property (lowerClose == (lowerRelayOn ? relayPullOe : '0)) else $error("lower");
   lower_follow_a: assert property (up == 2'h3 |-> lowerRelayOn == $past(lower_cmd, 3)) else $error("lower");
   raise_lock_a: assert property (up == 2'h3 |-> raiseRelayOn == ($past(raise_cmd, 3) && !$past(lower_cmd, 3)))
      else $error("raise lock");
   idle_release_a: assert property (up == 2'h3 && $past(idle, 3) |-> relayPullOe == '0) else $error("idle");
   bad_code_a: assert property (up == 2'h3 && $past(chanSel[3], 3) |-> relayPullOe == '0) else $error("code");
   cover property (raiseRelayOn && |raiseClose);
   cover property (lowerRelayOn && |lowerClose);
   cover property ($rose(|relayPullOe));
endmodule

// ---- bench/remote_terminal_model.sv ----
// Remote terminal model: break-before-make channel select and command lockout
`timescale 1ns/100ps
module remote_terminal_model (
   input wire logic       clk, act, rq, lq,
   input wire logic [4:0] chan,
   output logic     [3:0] chanSel,
   output logic           group_en_first_n, group_en_second_n, group_en_third_n, group_en_fourth_n,
   output logic           raise_cmd, lower_cmd
);
   logic [5:0] cur_r = '0;
   logic [1:0] gap_r = '0, cmd_r = '0;
   wire        live = cur_r[5] && gap_r == 2'h0;
   always @(negedge clk) begin
      gap_r <= {act, chan} != cur_r ? 2'h3 : gap_r - (gap_r != 2'h0);
      cur_r <= {act, chan};
      cmd_r <= {rq & ~lq, lq & ~rq};
   end
   assign {group_en_fourth_n, group_en_third_n, group_en_second_n, group_en_first_n} =
      live ? ~(4'h1 << cur_r[4:3]) : 4'hf;
   // Released lines show the inverted code so a stale one never looks valid
   assign chanSel = live ? {1'b0, cur_r[2:0]} : {1'b1, ~cur_r[2:0]};
   assign {raise_cmd, lower_cmd} = cmd_r;
endmodule

// ---- bench/channel_relay_decoder_tb.sv ----
// Bench: three chained selector units behind a remote terminal model
`timescale 1ns/100ps
module channel_relay_decoder_tb;
   logic       clk = '0, resetn = '0, act = '0, rq = '0, lq = '0, raise_cmd, lower_cmd, ro[3], lo[3];
   logic       group_en_first_n, group_en_second_n, group_en_third_n, group_en_fourth_n;
   logic [4:0] chan = '0;
   logic [3:0] chanSel;
   logic [9:0] p[3], m[3], rc[3], lc[3], e;
   int         failures = 0, cmp_count = 0, seed = 32'h7e5f, v, corner[10] = '{19, 1, 10, 11, 20, 21, 30, 0, 31, 8};
   initial forever #50 clk = ~clk;
   remote_terminal_model TERM (.*);
   for (genvar u = 0; u < 3; u++) begin : unit
      channel_relay_decoder #(.UNIT(relay_pkg::unit_range_t'(u))) DUT (.*, .relayPullOe(p[u]), .meterConnect(m[u]),
         .raiseClose(rc[u]), .lowerClose(lc[u]), .raiseRelayOn(ro[u]), .lowerRelayOn(lo[u]));
   end
   task automatic check(logic ok, string s);
      cmp_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask
   task automatic step(int c, logic a, logic r, logic l);
      {chan, act, rq, lq} <= {c[4:0], a, r, l};
      repeat (9) @(negedge clk);
      for (int u = 0; u < 3; u++) begin
         e = (a && c > 10 * u && c <= 10 * u + 10) ? 10'h1 << (c - 10 * u - 1) : '0;
         check(p[u] === e && m[u] === e, "relay");
         check({ro[u], lo[u]} === {r & ~l, l & ~r}, "command");
         check(rc[u] === (r & ~l ? e : '0) && lc[u] === (l & ~r ? e : '0), "contacts");
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      resetn <= 1'b1;
      foreach (corner[i]) step(corner[i], i != 9, i[0], i[1]);
      $display("corner channels done");
      // Mid-run reset: relay pulls and both command relays must drop while reset is held, then the run resumes
      resetn <= 1'b0;
      repeat (3) @(negedge clk);
      for (int u = 0; u < 3; u++) check(p[u] === '0 && ro[u] === 1'b0 && lo[u] === 1'b0, "reset");
      resetn <= 1'b1;
      repeat (100) begin
         v = $random(seed);
         step(v[4:0], v[5] | v[6], v[7], v[8]);
      end
      $display("random channels done");
      complete_run();
   end
   initial begin
      #300000;
      failures++;
      complete_run();
   end
endmodule
bind channel_relay_decoder relay_decoder_asserts CHK (.*);
